// file: pkg/hsm_pkg.sv
// shared constants for the hot swap supervisor and power monitor
package hsm_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int COOL_TIME_S = 10;
    localparam int COOL_CYCLES = CLK_HZ * COOL_TIME_S;
    localparam logic [2:0] RETRY_LIMIT = 3'h7;
    // bad fet sense thresholds, given as sense codes
    localparam logic signed [15:0] FET_SENSE_MODEL1 = 16'sh0002;
    localparam logic signed [15:0] FET_SENSE_MODEL2 = 16'sh0004;
    localparam logic [11:0] GATE_LOW_CODE = 12'h100;
    // register offsets
    localparam logic [7:0] REG_MON_SETUP = 8'h00;
    localparam logic [7:0] REG_MON_TRIG = 8'h01;
    localparam logic [7:0] REG_POWER = 8'h02;
    localparam logic [7:0] REG_ENERGY_ACC = 8'h03;
    localparam logic [7:0] REG_ENERGY_ROLL = 8'h04;
    localparam logic [7:0] REG_ENERGY_CNT = 8'h05;
    localparam logic [7:0] REG_PEAK_CUR = 8'h06;
    localparam logic [7:0] REG_PEAK_SUP = 8'h07;
    localparam logic [7:0] REG_PEAK_AUX = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h09;
    localparam logic [7:0] REG_AVG_CUR = 8'h0A;
    localparam logic [7:0] REG_AVG_SUP = 8'h0B;
    localparam logic [7:0] REG_AVG_AUX = 8'h0C;
    // monitor setup fields
    localparam int SETUP_AVG_LSB = 0;
    localparam int SETUP_SINGLE_BIT = 3;
    localparam int SETUP_RANGE_BIT = 4;
    localparam int SETUP_AUX_BIT = 5;
    localparam int SETUP_EXT_BIT = 6;
    localparam int SETUP_FETALERT_BIT = 7;
    localparam logic [7:0] SETUP_RESET = 8'h80;
    localparam int TRIG_CONVERT_BIT = 0;
    localparam int TRIG_PEAK_CLR_BIT = 1;
    typedef enum logic [1:0] {
        HSM_OFF = 2'h0,
        HSM_ON = 2'h1,
        HSM_COOL = 2'h2,
        HSM_LOCK = 2'h3
    } hsm_state_e;
endpackage

// file: hdl/hsm_timer.sv
// restartable ten second down counter with done pulse
`timescale 1ns/1ps
module hsm_timer #(
    parameter int CYCLES = 100000000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic clear,
    output logic running,
    output logic done
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    // start reloads, clear aborts, done fires on the last tick
    assign cnt_next = start ? 32'(CYCLES) : clear ? 32'h0 : (cnt_reg != 32'h0) ? cnt_reg - 32'h1 : 32'h0;
    assign running = cnt_reg != 32'h0;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_reg <= 32'h0;
        else
            cnt_reg <= cnt_next;
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            done <= 1'b0;
        else
            done <= !start && !clear && (cnt_reg == 32'h1);
    end
endmodule

// file: hdl/hsm_accum.sv
// averager and peak tracker for one measurement channel
`timescale 1ns/1ps
module hsm_accum (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sample,
    input wire logic signed [15:0] value,
    input wire logic [2:0] avg_n,
    input wire logic peak_clr,
    output logic result_valid,
    output logic signed [15:0] result,
    output logic signed [15:0] peak
);
    logic signed [23:0] sum_reg;
    logic [7:0] cnt_reg;
    logic [7:0] last_idx;
    logic signed [23:0] sum_new;
    logic last;
    assign last_idx = 8'((9'h1 << avg_n) - 9'h1);
    assign sum_new = sum_reg + 24'(value);
    assign last = sample && (cnt_reg == last_idx);
    // divide by 2^N with an arithmetic shift, keeps sign
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sum_reg <= 24'sh0;
            cnt_reg <= 8'h0;
            result <= 16'sh0;
            result_valid <= 1'b0;
        end
        else
        begin
            result_valid <= last;
            if (last)
            begin
                result <= 16'(sum_new >>> avg_n);
                sum_reg <= 24'sh0;
                cnt_reg <= 8'h0;
            end
            else if (sample)
            begin
                sum_reg <= sum_new;
                cnt_reg <= cnt_reg + 8'h1;
            end
        end
    end
    // peak holds highest sample, clear reloads the floor
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            peak <= 16'sh8000;
        else if (peak_clr)
            peak <= 16'sh8000;
        else if (sample && value > peak)
            peak <= value;
    end
endmodule

// file: hdl/hsm_top.sv
// hot swap supervisor with digital power monitor
`timescale 1ns/1ps
module hsm_top #(
    parameter int COOL_CYCLES = hsm_pkg::COOL_CYCLES,
    parameter bit MODEL_TWO = 1'b0
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic SHUTDOWN_N_INPUT,
    input wire logic RESTART_N,
    input wire logic UNDERVOLTAGE_HIGH_IN,
    input wire logic UNDERVOLTAGE_LOW_IN,
    input wire logic OVERCURRENT_TRIP,
    input wire logic POWER_GOOD,
    input wire logic signed [15:0] SENSE_CODE,
    input wire logic [11:0] SUPPLY_CODE,
    input wire logic [11:0] AUX_CODE,
    input wire logic [11:0] GATE_CODE,
    input wire logic ADC_STROBE,
    input wire logic ALERT_ONE_TRIGGER_PIN_IN,
    input wire logic BUS_STOP,
    input wire logic BUS_GROUP,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic GATE_ON,
    output logic FAULT_LOCKOUT_N,
    output logic ALERT_TWO_OUT_N,
    output logic ALERT_ONE_TRIGGER_PIN_OUT,
    output logic ALERT_ONE_TRIGGER_PIN_OE,
    output logic RANGE_50MV
);
    hsm_pkg::hsm_state_e state_reg;
    hsm_pkg::hsm_state_e state_next;
    logic [7:0] setup_reg;
    logic [2:0] retry_reg;
    logic retry_limit_reg;
    logic shutdown_n_input_d_reg;
    logic restart_d_reg;
    logic uvh_d_reg;
    logic uvl_d_reg;
    logic ext_d_reg;
    logic trig_pending_reg;
    logic busy_reg;
    logic [31:0] power_reg;
    logic [31:0] acc_reg;
    logic [15:0] roll_reg;
    logic [31:0] samples_reg;
    logic [31:0] snap_acc_reg;
    logic [15:0] snap_roll_reg;
    logic [31:0] snap_cnt_reg;
    logic [31:0] rdata_reg;

    // decoded controls
    wire logic shutdown_n_input_fall = shutdown_n_input_d_reg && !SHUTDOWN_N_INPUT;
    wire logic shutdown_n_input_rise = !shutdown_n_input_d_reg && SHUTDOWN_N_INPUT;
    wire logic restart_fall = restart_d_reg && !RESTART_N;
    wire logic uv_toggle = (uvh_d_reg != UNDERVOLTAGE_HIGH_IN) || (uvl_d_reg != UNDERVOLTAGE_LOW_IN);
    wire logic uv_ok = UNDERVOLTAGE_HIGH_IN && UNDERVOLTAGE_LOW_IN;
    wire logic fault_event = (state_reg == hsm_pkg::HSM_ON) && (OVERCURRENT_TRIP || shutdown_n_input_fall);
    wire logic cool_done;
    wire logic cool_running;
    wire logic pg_done;
    wire logic pg_running;
    wire logic [2:0] avg_n = setup_reg[hsm_pkg::SETUP_AVG_LSB +: 3];
    wire logic single_mode = setup_reg[hsm_pkg::SETUP_SINGLE_BIT];
    wire logic aux_en = setup_reg[hsm_pkg::SETUP_AUX_BIT];
    wire logic ext_mode = setup_reg[hsm_pkg::SETUP_EXT_BIT];
    wire logic wr_setup = WR && (ADDR == hsm_pkg::REG_MON_SETUP);
    wire logic wr_trig = WR && (ADDR == hsm_pkg::REG_MON_TRIG);
    wire logic convert_bit = wr_trig && WDATA[hsm_pkg::TRIG_CONVERT_BIT];
    wire logic peak_clr = wr_trig && WDATA[hsm_pkg::TRIG_PEAK_CLR_BIT];
    wire logic ext_rise = ext_mode && !ext_d_reg && ALERT_ONE_TRIGGER_PIN_IN;
    wire logic signed [15:0] fet_thresh = MODEL_TWO ? hsm_pkg::FET_SENSE_MODEL2 : hsm_pkg::FET_SENSE_MODEL1;

    wire logic fet_bad = (state_reg != hsm_pkg::HSM_ON) && (SENSE_CODE > fet_thresh)
        && (GATE_CODE < hsm_pkg::GATE_LOW_CODE);

    wire logic trig_now = (convert_bit && !BUS_GROUP) || (trig_pending_reg && BUS_STOP) || ext_rise;

    wire logic shot_start = single_mode && !busy_reg && trig_now;

    wire logic take = ADC_STROBE && (!single_mode || busy_reg);
    wire logic take_aux = take && aux_en;
    wire logic cur_valid;
    wire logic signed [15:0] cur_avg;
    wire logic signed [15:0] sup_avg;
    wire logic signed [15:0] aux_avg;
    wire logic signed [15:0] cur_peak;
    wire logic signed [15:0] sup_peak;
    wire logic signed [15:0] aux_peak;

    wire logic signed [31:0] power_now = SENSE_CODE * $signed({4'h0, SUPPLY_CODE});
    wire logic [32:0] acc_sum = {1'b0, acc_reg} + {1'b0, power_now};

    hsm_timer #(.CYCLES(COOL_CYCLES)) u_cool (
        .clk(CLK),
        .rst_n(RSTN),
        .start(restart_fall),
        .clear(1'b0),
        .running(cool_running),
        .done(cool_done)
    );

    // power good watchdog, aborts whenever good drops
    hsm_timer #(.CYCLES(COOL_CYCLES)) u_pg (
        .clk(CLK),
        .rst_n(RSTN),
        .start(POWER_GOOD && !pg_running && retry_reg != 3'h0),
        .clear(!POWER_GOOD),
        .running(pg_running),
        .done(pg_done)
    );

    // current and supply channels always, aux optional
    hsm_accum u_cur (
        .clk(CLK),
        .rst_n(RSTN),
        .sample(take),
        .value(SENSE_CODE),
        .avg_n(avg_n),
        .peak_clr(peak_clr),
        .result_valid(cur_valid),
        .result(cur_avg),
        .peak(cur_peak)
    );
    hsm_accum u_sup (
        .clk(CLK),
        .rst_n(RSTN),
        .sample(take),
        .value($signed({4'h0, SUPPLY_CODE})),
        .avg_n(avg_n),
        .peak_clr(peak_clr),
        .result_valid(),
        .result(sup_avg),
        .peak(sup_peak)
    );
    hsm_accum u_aux (
        .clk(CLK),
        .rst_n(RSTN),
        .sample(take_aux),
        .value($signed({4'h0, AUX_CODE})),
        .avg_n(avg_n),
        .peak_clr(peak_clr),
        .result_valid(),
        .result(aux_avg),
        .peak(aux_peak)
    );

    // hot swap state sequencing
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            hsm_pkg::HSM_OFF:
                if (uv_ok && SHUTDOWN_N_INPUT && !retry_limit_reg && !cool_running)
                    state_next = hsm_pkg::HSM_ON;
            hsm_pkg::HSM_ON:
                if (!SHUTDOWN_N_INPUT || !uv_ok)
                    state_next = hsm_pkg::HSM_OFF;
                else if (OVERCURRENT_TRIP)
                    state_next = hsm_pkg::HSM_LOCK;
            hsm_pkg::HSM_COOL:
                if (cool_done)
                    state_next = hsm_pkg::HSM_OFF;
            hsm_pkg::HSM_LOCK:
                if (uv_toggle || shutdown_n_input_rise)
                    state_next = hsm_pkg::HSM_OFF;
            default:
                state_next = hsm_pkg::HSM_OFF;
        endcase
        // only the falling edge starts cooling
        if (restart_fall)
            state_next = hsm_pkg::HSM_COOL;
        else if (uv_toggle && state_next == hsm_pkg::HSM_LOCK)
            state_next = hsm_pkg::HSM_OFF;
    end

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            state_reg <= hsm_pkg::HSM_OFF;
        else
            state_reg <= state_next;
    end

    // input edge history
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            shutdown_n_input_d_reg <= 1'b1;
            restart_d_reg <= 1'b1;
            // supply-ok level, so release gives no false toggle
            uvh_d_reg <= 1'b1;
            uvl_d_reg <= 1'b1;
            ext_d_reg <= 1'b0;
        end
        else
        begin
            shutdown_n_input_d_reg <= SHUTDOWN_N_INPUT;
            restart_d_reg <= RESTART_N;
            uvh_d_reg <= UNDERVOLTAGE_HIGH_IN;
            uvl_d_reg <= UNDERVOLTAGE_LOW_IN;
            ext_d_reg <= ALERT_ONE_TRIGGER_PIN_IN;
        end
    end

    // retry counting; a new event beats the clears
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            retry_reg <= 3'h0;
            retry_limit_reg <= 1'b0;
        end
        else if (fault_event)
        begin
            retry_reg <= (retry_reg == hsm_pkg::RETRY_LIMIT) ? retry_reg : retry_reg + 3'h1;
            if (retry_reg == hsm_pkg::RETRY_LIMIT - 3'h1)
                retry_limit_reg <= 1'b1;
        end
        else if (uv_toggle)
        begin
            retry_reg <= 3'h0;
            retry_limit_reg <= 1'b0;
        end
        // power good clears counter; limit untouched by power good
        else if (pg_done)
            retry_reg <= 3'h0;
    end

    // monitor setup and trigger handling
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            setup_reg <= hsm_pkg::SETUP_RESET;
            trig_pending_reg <= 1'b0;
            busy_reg <= 1'b0;
        end
        else
        begin
            if (wr_setup)
                setup_reg <= WDATA[7:0];
            if (convert_bit && BUS_GROUP)
                trig_pending_reg <= 1'b1;
            else if (BUS_STOP)
                trig_pending_reg <= 1'b0;
            // one averaged result ends the shot
            if (shot_start)
                busy_reg <= 1'b1;
            else if (cur_valid)
                busy_reg <= 1'b0;
        end
    end

    // energy path; 32 bit wide product fits one accumulator step
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            power_reg <= 32'h0;
            acc_reg <= 32'h0;
            roll_reg <= 16'h0;
            samples_reg <= 32'h0;
        end
        else if (take)
        begin
            power_reg <= power_now;
            acc_reg <= acc_sum[31:0];
            if (acc_sum[32])
                roll_reg <= roll_reg + 16'h1;
            samples_reg <= samples_reg + 32'h1;
        end
    end

    // snapshot when the accumulator word is read
    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            snap_acc_reg <= 32'h0;
            snap_roll_reg <= 16'h0;
            snap_cnt_reg <= 32'h0;
        end
        else if (RD && ADDR == hsm_pkg::REG_ENERGY_ACC)
        begin
            snap_acc_reg <= acc_reg;
            snap_roll_reg <= roll_reg;
            snap_cnt_reg <= samples_reg;
        end
    end

    // read mux; unmapped reads give zero
    // setup, trigger, power, energy, peak, status and average reads
    wire logic [31:0] rd_mux =
        (ADDR == hsm_pkg::REG_MON_SETUP) ? {24'h0, setup_reg} :
        (ADDR == hsm_pkg::REG_MON_TRIG) ? {31'h0, busy_reg} :
        (ADDR == hsm_pkg::REG_POWER) ? power_reg :
        (ADDR == hsm_pkg::REG_ENERGY_ACC) ? acc_reg :
        (ADDR == hsm_pkg::REG_ENERGY_ROLL) ? {16'h0, snap_roll_reg} :
        (ADDR == hsm_pkg::REG_ENERGY_CNT) ? snap_cnt_reg :
        (ADDR == hsm_pkg::REG_PEAK_CUR) ? {{16{cur_peak[15]}}, cur_peak} :
        (ADDR == hsm_pkg::REG_PEAK_SUP) ? {16'h0, sup_peak} :
        (ADDR == hsm_pkg::REG_PEAK_AUX) ? {16'h0, aux_peak} :
        (ADDR == hsm_pkg::REG_STATUS) ? {24'h0, fet_bad, retry_limit_reg, retry_reg, 1'b0, state_reg} :
        (ADDR == hsm_pkg::REG_AVG_CUR) ? {{16{cur_avg[15]}}, cur_avg} :
        (ADDR == hsm_pkg::REG_AVG_SUP) ? {16'h0, sup_avg} :
        (ADDR == hsm_pkg::REG_AVG_AUX) ? {16'h0, aux_avg} :
        32'h0;

    always_ff @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
            rdata_reg <= 32'h0;
        else if (RD)
            rdata_reg <= rd_mux;
        else
            rdata_reg <= 32'h0;
    end

    assign RDATA = rdata_reg;
    assign GATE_ON = state_reg == hsm_pkg::HSM_ON;
    assign FAULT_LOCKOUT_N = state_reg != hsm_pkg::HSM_LOCK;
    assign ALERT_TWO_OUT_N = !retry_limit_reg;
    // open drain alert on bad fet, idle in external mode
    assign ALERT_ONE_TRIGGER_PIN_OUT = 1'b0;
    assign ALERT_ONE_TRIGGER_PIN_OE = !ext_mode && setup_reg[hsm_pkg::SETUP_FETALERT_BIT] && fet_bad;
    assign RANGE_50MV = setup_reg[hsm_pkg::SETUP_RANGE_BIT];
endmodule

// file: test/hsm_top_sva.sv
// concurrent checks on the supervisor ports
`timescale 1ns/1ps
module hsm_top_sva #(
    parameter int COOL_CYCLES = 50
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic SHUTDOWN_N_INPUT,
    input wire logic RESTART_N,
    input wire logic UNDERVOLTAGE_HIGH_IN,
    input wire logic UNDERVOLTAGE_LOW_IN,
    input wire logic OVERCURRENT_TRIP,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic GATE_ON,
    input wire logic FAULT_LOCKOUT_N,
    input wire logic ALERT_TWO_OUT_N,
    input wire logic ALERT_ONE_TRIGGER_PIN_OE,
    input wire logic RANGE_50MV
);
    // slack covers the off state between cooling and on
    localparam int RB_LO = COOL_CYCLES - 2;
    localparam int RB_HI = COOL_CYCLES + 20;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    property p_shutdown_n_input_gate;
        !SHUTDOWN_N_INPUT && $past(!SHUTDOWN_N_INPUT) |-> !GATE_ON;
    endproperty
    a_shutdown_n_input_gate: assert property (p_shutdown_n_input_gate)
        else $error("gate on in shutdown");
    property p_limit_gate;
        !ALERT_TWO_OUT_N && $past(!ALERT_TWO_OUT_N) |-> !GATE_ON;
    endproperty
    a_limit_gate: assert property (p_limit_gate)
        else $error("gate on at retry limit");
    property p_keep_alert;
        !ALERT_TWO_OUT_N && $stable(UNDERVOLTAGE_HIGH_IN) && $stable(UNDERVOLTAGE_LOW_IN) |=> !ALERT_TWO_OUT_N;
    endproperty
    a_keep_alert: assert property (p_keep_alert)
        else $error("retry alert cleared without undervoltage toggle");
    property p_uv_clear;
        ($changed(UNDERVOLTAGE_HIGH_IN) || $changed(UNDERVOLTAGE_LOW_IN)) && SHUTDOWN_N_INPUT
            && !OVERCURRENT_TRIP |=> ALERT_TWO_OUT_N;
    endproperty
    a_uv_clear: assert property (p_uv_clear)
        else $error("undervoltage toggle left retry alert");
    property p_restart_off;
        $fell(RESTART_N) |-> ##2 (!GATE_ON) [*8];
    endproperty
    a_restart_off: assert property (p_restart_off)
        else $error("gate on during cooling");
    property p_restart_back;
        $fell(RESTART_N) && SHUTDOWN_N_INPUT && ALERT_TWO_OUT_N && FAULT_LOCKOUT_N && UNDERVOLTAGE_HIGH_IN
            && UNDERVOLTAGE_LOW_IN && !OVERCURRENT_TRIP |-> ##[RB_LO:RB_HI] GATE_ON;
    endproperty
    a_restart_back: assert property (p_restart_back)
        else $error("gate not back after cooling");
    property p_restart_once;
        GATE_ON && !RESTART_N && $past(!RESTART_N) && SHUTDOWN_N_INPUT && !OVERCURRENT_TRIP
            && $stable(UNDERVOLTAGE_HIGH_IN) && $stable(UNDERVOLTAGE_LOW_IN) |=> GATE_ON;
    endproperty
    a_restart_once: assert property (p_restart_once)
        else $error("held restart gave a second cycle");
    property p_lockout;
        $rose(OVERCURRENT_TRIP) && GATE_ON |-> ##[1:3] !FAULT_LOCKOUT_N;
    endproperty
    a_lockout: assert property (p_lockout)
        else $error("no lockout after overcurrent");
    property p_fet_off;
        ALERT_ONE_TRIGGER_PIN_OE |-> !GATE_ON;
    endproperty
    a_fet_off: assert property (p_fet_off)
        else $error("bad fet alert while gate driven");
    property p_range;
        WR && ADDR == hsm_pkg::REG_MON_SETUP |=> RANGE_50MV == $past(WDATA[hsm_pkg::SETUP_RANGE_BIT]);
    endproperty
    a_range: assert property (p_range)
        else $error("range output not from setup write");
endmodule

bind hsm_top hsm_top_sva #(.COOL_CYCLES(COOL_CYCLES)) u_hsm_top_sva (
    .CLK(CLK),
    .RSTN(RSTN),
    .SHUTDOWN_N_INPUT(SHUTDOWN_N_INPUT),
    .RESTART_N(RESTART_N),
    .UNDERVOLTAGE_HIGH_IN(UNDERVOLTAGE_HIGH_IN),
    .UNDERVOLTAGE_LOW_IN(UNDERVOLTAGE_LOW_IN),
    .OVERCURRENT_TRIP(OVERCURRENT_TRIP),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .WR(WR),
    .GATE_ON(GATE_ON),
    .FAULT_LOCKOUT_N(FAULT_LOCKOUT_N),
    .ALERT_TWO_OUT_N(ALERT_TWO_OUT_N),
    .ALERT_ONE_TRIGGER_PIN_OE(ALERT_ONE_TRIGGER_PIN_OE),
    .RANGE_50MV(RANGE_50MV)
);

// file: test/hsm_plant_model.sv
// plant model: paired sample source and power good follower
`timescale 1ns/1ps
module hsm_plant_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic gate_on,
    input wire logic signed [15:0] cur_in,
    input wire logic [11:0] sup_in,
    input wire logic [11:0] gate_in,
    output logic strobe,
    output logic signed [15:0] sense,
    output logic [11:0] supply,
    output logic [11:0] gate_v,
    output logic power_good
);
    logic [1:0] phase_reg;
    // codes latch two cycles before the strobe, so a pair never straddles a change
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_reg <= 2'h0;
            strobe <= 1'b0;
            sense <= 16'sh0000;
            supply <= 12'h000;
            gate_v <= 12'hFFF;
            power_good <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_reg + 2'h1;
            strobe <= (phase_reg == 2'h2);
            power_good <= gate_on;
            if (phase_reg == 2'h0)
            begin
                sense <= cur_in;
                supply <= sup_in;
                gate_v <= gate_in;
            end
        end
    end
endmodule

// file: test/hsm_top_tb_top.sv
// self-checking bench for the hot swap supervisor and power monitor
`timescale 1ns/1ps
module hsm_top_tb_top;
    localparam int COOL = 50;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic shutdown_n_input_n = 1'b1;
    logic restart_n = 1'b1;
    logic undervoltage_high_in = 1'b1;
    logic undervoltage_low_in = 1'b1;
    logic oc = 1'b0;
    logic pin_in = 1'b0;
    logic bus_stop = 1'b0;
    logic bus_group = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic signed [15:0] cur = 16'sh0064;
    logic [11:0] gte = 12'h800;
    logic pgood, strobe, gate_on, lock_n, alert2_n, pin_out, pin_oe, range50;
    logic signed [15:0] sense;
    logic [11:0] supply, gate_v;
    logic [31:0] rdata, a1, r1, c1, a2, r2, c2;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    hsm_plant_model u_hsm_plant_model (.clk(clk), .rst_n(rstn), .gate_on(gate_on), .cur_in(cur), .sup_in(12'h0C8),
        .gate_in(gte), .strobe(strobe), .sense(sense), .supply(supply), .gate_v(gate_v), .power_good(pgood));
    hsm_top #(.COOL_CYCLES(COOL)) u_hsm_top (.CLK(clk), .RSTN(rstn), .SHUTDOWN_N_INPUT(shutdown_n_input_n),
        .RESTART_N(restart_n), .UNDERVOLTAGE_HIGH_IN(undervoltage_high_in), .UNDERVOLTAGE_LOW_IN(undervoltage_low_in), .OVERCURRENT_TRIP(oc),
        .POWER_GOOD(pgood), .SENSE_CODE(sense), .SUPPLY_CODE(supply), .AUX_CODE(supply), .GATE_CODE(gate_v),
        .ADC_STROBE(strobe), .ALERT_ONE_TRIGGER_PIN_IN(pin_in), .BUS_STOP(bus_stop), .BUS_GROUP(bus_group),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .GATE_ON(gate_on), .FAULT_LOCKOUT_N(lock_n),
        .ALERT_TWO_OUT_N(alert2_n), .ALERT_ONE_TRIGGER_PIN_OUT(pin_out), .ALERT_ONE_TRIGGER_PIN_OE(pin_oe),
        .RANGE_50MV(range50));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_reg(input string name, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] d;
        rd_reg(a, d);
        check(name, exp & m, d & m);
    endtask
    // busy may lag the trigger, so poll only after a short pause
    task automatic wait_idle;
        logic [31:0] d;
        d = 32'h1;
        cyc(3);
        for (int k = 0; k < 200 && d[0] !== 1'b0; k++) rd_reg(hsm_pkg::REG_MON_TRIG, d);
        check("busy", 32'h0, {31'h0, d[0]});
    endtask
    task automatic toggle_shutdown_n_input;
        @(posedge clk);
        shutdown_n_input_n <= 1'b0;
        cyc(4);
        shutdown_n_input_n <= 1'b1;
        cyc(4);
    endtask
    task automatic tally_and_finish;
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial
    begin
        cyc(4);
        rstn <= 1'b1;
        cyc(12);
        check_reg("setup", hsm_pkg::REG_MON_SETUP, 32'h80, 32'hFF);
        check("gate", 32'h1, gate_on);
        check_reg("power", hsm_pkg::REG_POWER, 32'd20000, 32'hFFFFFFFF);
        check_reg("avg sup", hsm_pkg::REG_AVG_SUP, 32'h0C8, 32'hFFF);
        rd_reg(hsm_pkg::REG_ENERGY_ACC, a1);
        rd_reg(hsm_pkg::REG_ENERGY_ROLL, r1);
        rd_reg(hsm_pkg::REG_ENERGY_CNT, c1);
        cyc(40);
        rd_reg(hsm_pkg::REG_ENERGY_ACC, a2);
        rd_reg(hsm_pkg::REG_ENERGY_ROLL, r2);
        rd_reg(hsm_pkg::REG_ENERGY_CNT, c2);
        check("samples grew", 32'h1, c2 > c1);
        check("energy delta", (c2 - c1) * 32'd20000, a2 - a1);
        check("rollover", r1, r2);
        cur <= -16'sd30;
        cyc(12);
        check_reg("avg cur", hsm_pkg::REG_AVG_CUR, 32'hFFE2, 32'hFFFF);
        check_reg("peak cur", hsm_pkg::REG_PEAK_CUR, 32'h0064, 32'hFFFF);
        wr_reg(hsm_pkg::REG_MON_TRIG, 32'h2);
        cyc(12);
        check_reg("peak clr", hsm_pkg::REG_PEAK_CUR, 32'hFFE2, 32'hFFFF);
        wr_reg(hsm_pkg::REG_MON_SETUP, 32'hBA);
        #1;
        check("range", 32'h1, range50);
        cur <= 16'sd40;
        cyc(8);
        wr_reg(hsm_pkg::REG_MON_TRIG, 32'h1);
        wait_idle();
        check_reg("single", hsm_pkg::REG_AVG_CUR, 32'h28, 32'hFFFF);
        check_reg("avg aux", hsm_pkg::REG_AVG_AUX, 32'h0C8, 32'hFFFF);
        check_reg("peak aux", hsm_pkg::REG_PEAK_AUX, 32'h0C8, 32'hFFFF);
        check_reg("peak sup", hsm_pkg::REG_PEAK_SUP, 32'h0C8, 32'hFFFF);
        cur <= 16'sd60;
        bus_group <= 1'b1;
        wr_reg(hsm_pkg::REG_MON_TRIG, 32'h1);
        bus_group <= 1'b0;
        cyc(30);
        check_reg("group held", hsm_pkg::REG_AVG_CUR, 32'h28, 32'hFFFF);
        bus_stop <= 1'b1;
        cyc(1);
        bus_stop <= 1'b0;
        wait_idle();
        check_reg("group run", hsm_pkg::REG_AVG_CUR, 32'h3C, 32'hFFFF);
        wr_reg(hsm_pkg::REG_MON_SETUP, 32'hDA);
        cur <= 16'sd80;
        cyc(8);
        pin_in <= 1'b1;
        wait_idle();
        check_reg("pin run", hsm_pkg::REG_AVG_CUR, 32'h50, 32'hFFFF);
        pin_in <= 1'b0;
        wr_reg(hsm_pkg::REG_MON_SETUP, 32'h80);
        shutdown_n_input_n <= 1'b0;
        cur <= 16'sd3;
        gte <= 12'h050;
        cyc(12);
        check("shutdown_n_input gate", 32'h0, gate_on);
        check("fet bad", 32'h1, pin_oe);
        check("pin level", 32'h0, pin_out);
        gte <= 12'h200;
        cyc(12);
        check("gate high", 32'h0, pin_oe);
        gte <= 12'h050;
        cur <= 16'sd2;
        cyc(12);
        check("sense low", 32'h0, pin_oe);
        cur <= 16'sd100;
        gte <= 12'h800;
        shutdown_n_input_n <= 1'b1;
        undervoltage_high_in <= 1'b0;
        cyc(3);
        undervoltage_high_in <= 1'b1;
        cyc(6);
        for (int i = 1; i <= 7; i++)
        begin
            toggle_shutdown_n_input();
            check("rearm", i < 7, gate_on);
        end
        check("limit", 32'h0, alert2_n);
        toggle_shutdown_n_input();
        check("limit kept", 32'h0, alert2_n);
        undervoltage_low_in <= 1'b0;
        cyc(3);
        undervoltage_low_in <= 1'b1;
        cyc(6);
        check("uv clear", 32'h1, alert2_n);
        check("uv gate", 32'h1, gate_on);
        repeat (3) toggle_shutdown_n_input();
        check_reg("retries", hsm_pkg::REG_STATUS, 32'h18, 32'h38);
        cyc(COOL + 20);
        check_reg("retries clr", hsm_pkg::REG_STATUS, 32'h0, 32'h38);
        restart_n <= 1'b0;
        cyc(5);
        check("cool off", 32'h0, gate_on);
        cyc(COOL + 15);
        check("cool back", 32'h1, gate_on);
        cyc(100);
        check("one restart", 32'h1, gate_on);
        restart_n <= 1'b1;
        cyc(4);
        oc <= 1'b1;
        cyc(1);
        oc <= 1'b0;
        cyc(3);
        check("lockout", 32'h0, lock_n);
        check("lock gate", 32'h0, gate_on);
        check_reg("unmapped", 8'hFF, 32'h0, 32'hFFFFFFFF);
        tally_and_finish();
    end
endmodule
